/* hw/seeae_pkg.sv */
// Shared constants and types of the serial EEPROM access engine
package seeae_pkg;

	// Clock and timing
	localparam int unsigned SEEAE_CLK_HZ         = 10_000_000;
	localparam int unsigned SEEAE_T_WRITE_US     = 5000;
	localparam int unsigned SEEAE_WRITE_CYCLES   = SEEAE_T_WRITE_US * (SEEAE_CLK_HZ / 1_000_000);
	localparam int unsigned SEEAE_WTIMER_W       = 20;
	localparam int unsigned SEEAE_T_SCL_NS       = 10000;
	localparam int unsigned SEEAE_QUARTER_CYCLES = (SEEAE_T_SCL_NS * (SEEAE_CLK_HZ / 1_000_000)) / (4 * 1000);
	localparam logic [7:0]  SEEAE_QTR_LOAD       = 8'(SEEAE_QUARTER_CYCLES - 1);

	// Array geometry
	localparam int unsigned SEEAE_MEM_BYTES  = 65536;
	localparam int unsigned SEEAE_PAGE_BYTES = 128;
	localparam logic [3:0]  SEEAE_BITS_BYTE  = 4'h8;

	// Device type code; the value is arbitrary
	localparam logic [3:0] SEEAE_DEV_CODE = 4'h5;

	// Host register offsets
	localparam logic [1:0] SEEAE_REG_CMD    = 2'h0;
	localparam logic [1:0] SEEAE_REG_DATA   = 2'h1;
	localparam logic [1:0] SEEAE_REG_STATUS = 2'h2;

	// Command and status field positions
	localparam int unsigned SEEAE_CMD_START    = 0;
	localparam int unsigned SEEAE_CMD_STOP     = 1;
	localparam int unsigned SEEAE_CMD_READ     = 2;
	localparam int unsigned SEEAE_CMD_NACK     = 3;
	localparam int unsigned SEEAE_CMD_STOPONLY = 4;
	localparam int unsigned SEEAE_ST_BUSY      = 0;
	localparam int unsigned SEEAE_ST_NACKED    = 1;

	// Reset values
	localparam logic [7:0]  SEEAE_RST_BYTE = 8'h00;
	localparam logic [15:0] SEEAE_RST_PTR  = 16'h0000;

	// Device link states
	typedef enum logic [2:0] {
		DS_IDLE   = 3'b000,
		DS_RX     = 3'b001,
		DS_RX_ACK = 3'b011,
		DS_TX     = 3'b010,
		DS_TX_ACK = 3'b110
	} seeae_dev_state_type;

	// Meaning of the byte being received
	typedef enum logic [1:0] {
		BK_CTRL = 2'b00,
		BK_AHI  = 2'b01,
		BK_ALO  = 2'b11,
		BK_DATA = 2'b10
	} seeae_kind_type;

	// Host sequencer states
	typedef enum logic [1:0] {
		HS_IDLE  = 2'b00,
		HS_START = 2'b01,
		HS_BIT   = 2'b11,
		HS_STOP  = 2'b10
	} seeae_host_state_type;

endpackage : seeae_pkg

/* hw/seeae_link_if.sv */
// Two-wire link between host and device, with open-drain data resolution
`timescale 1ns/1ps
interface seeae_link_if;
	logic scl;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic sda;

	// Wired-AND with pull-up: low when any enabled driver drives low
	assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

	modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
	modport dev  (input scl, output dev_sda_o, output dev_sda_oe, input sda);
endinterface : seeae_link_if

/* hw/seeae_sync.sv */
// Pin synchroniser and bus event detector of the device end
`timescale 1ns/1ps
module seeae_sync (
	// Clock, reset and enable
	input  logic       clk_i,
	input  logic       rst_i,
	input  logic       ce_i,
	// Asynchronous pins
	input  logic       scl_i,
	input  logic       sda_i,
	input  logic       wp_i,
	input  logic [2:0] cs_i,
	// Synchronised levels and events
	output logic       sda_o,
	output logic       wp_o,
	output logic [2:0] cs_o,
	output logic       scl_rise_o,
	output logic       scl_fall_o,
	output logic       start_o,
	output logic       stop_o
);
	logic [5:0] meta;
	logic [5:0] sync;
	logic [1:0] last;
	logic [5:0] next_meta;
	logic [5:0] next_sync;
	logic [1:0] next_last;

	// Stage one feeds only stage two; edges compare stage two with its delayed copy
	always_comb begin
		next_meta = {cs_i, wp_i, sda_i, scl_i};
		next_sync = meta;
		next_last = sync[1:0];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta <= 6'h03;
			sync <= 6'h03;
			last <= 2'h3;
		end else if (ce_i) begin
			meta <= next_meta;
			sync <= next_sync;
			last <= next_last;
		end
	end

	// Start and stop need the clock high on both samples
	assign sda_o      = sync[1];
	assign wp_o       = sync[2];
	assign cs_o       = sync[5:3];
	assign scl_rise_o = sync[0] && !last[0];
	assign scl_fall_o = !sync[0] && last[0];
	assign start_o    = sync[0] && last[0] && !sync[1] && last[1];
	assign stop_o     = sync[0] && last[0] && sync[1] && !last[1];
endmodule : seeae_sync

/* hw/seeae_device.sv */
// Serial EEPROM device end: slave transaction logic, page buffer and array
// Functional notes
// - Master maps address bits 16-18 onto chip selects
// - Read bursts never cross into another device
// - Write control byte: code, selects, zero; ninth-clock ack
// - High then low address byte load pointer
// - Stop starts write; no ack until done
// - Protected write: ack all, write nothing, stay ready
// - Byte write leaves pointer after written byte
// - Short write refreshes rest of page
// - Up to 127 more bytes buffered until Stop
// - Low seven pointer bits wrap; excess overwrites
// - Protect sampled at Stop, covers whole array
// - Master keeps page writes inside one page
// - Master polls with write control bytes
// - Ack polling control byte once write done
// - Read bit one; three read types
// - Current read sends next byte, ends on nack
// - Random read: address write, repeated Start
// - Random read leaves pointer after read byte
// - Master ack fetches next byte; nack ends
// - Read pointer wraps FFFF to 0000
// - Ack only matching code and chip selects
// - Release data line after master nack
`timescale 1ns/1ps
module seeae_device
	import seeae_pkg::*;
#(
	parameter int unsigned WRITE_CYCLES = SEEAE_WRITE_CYCLES
) (
	// Clock, reset and enable
	input  logic       CORE_CLK_I,
	input  logic       RST_I,
	input  logic       CE_I,
	// Strap pins
	input  logic       WP_I,
	input  logic [2:0] CS_I,
	// Status
	output logic       BUSY_O,
	// Two-wire link
	seeae_link_if.dev  LINK
);
	// Synchronised link
	logic                      sda;
	logic                      wp;
	logic [2:0]                cs;
	logic                      scl_rise;
	logic                      scl_fall;
	logic                      start;
	logic                      stop;
	// Control state
	seeae_dev_state_type       state;
	seeae_kind_type            kind;
	logic [3:0]                bit_cnt;
	logic [7:0]                shreg;
	logic [15:0]               ptr;
	logic                      rw;
	logic                      m_ack;
	logic                      sda_oe;
	logic                      wr_pend;
	logic                      busy;
	logic [SEEAE_WTIMER_W-1:0] wtimer;
	logic [SEEAE_PAGE_BYTES-1:0] mask;
	seeae_dev_state_type       next_state;
	seeae_kind_type            next_kind;
	logic [3:0]                next_bit_cnt;
	logic [7:0]                next_shreg;
	logic [15:0]               next_ptr;
	logic                      next_rw;
	logic                      next_m_ack;
	logic                      next_sda_oe;
	logic                      next_wr_pend;
	logic                      next_busy;
	logic [SEEAE_WTIMER_W-1:0] next_wtimer;
	logic [SEEAE_PAGE_BYTES-1:0] next_mask;
	// Storage strobes
	logic                      buf_we;
	logic                      commit;
	// Storage
	logic [7:0]                page_buf [0:SEEAE_PAGE_BYTES-1];
	logic [7:0]                mem      [0:SEEAE_MEM_BYTES-1];
	seeae_sync u_sync (
		.clk_i      (CORE_CLK_I),
		.rst_i      (RST_I),
		.ce_i       (CE_I),
		.scl_i      (LINK.scl),
		.sda_i      (LINK.sda),
		.wp_i       (WP_I),
		.cs_i       (CS_I),
		.sda_o      (sda),
		.wp_o       (wp),
		.cs_o       (cs),
		.scl_rise_o (scl_rise),
		.scl_fall_o (scl_fall),
		.start_o    (start),
		.stop_o     (stop)
	);
	// Link sequencer; start and stop override any bit in progress
	always_comb begin
		next_state   = state;
		next_kind    = kind;
		next_bit_cnt = bit_cnt;
		next_shreg   = shreg;
		next_ptr     = ptr;
		next_rw      = rw;
		next_m_ack   = m_ack;
		next_sda_oe  = sda_oe;
		next_wr_pend = wr_pend;
		next_busy    = busy;
		next_wtimer  = wtimer;
		next_mask    = mask;
		buf_we       = 1'b0;
		commit       = 1'b0;
		// Self-timed write cycle
		if (busy) begin
			next_wtimer = wtimer - SEEAE_WTIMER_W'(1);
			if (wtimer == SEEAE_WTIMER_W'(1)) begin
				next_busy = 1'b0;
				commit    = 1'b1;
			end
		end
		if (start) begin
			// A repeated start drops data not closed by a stop
			next_state   = DS_RX;
			next_kind    = BK_CTRL;
			next_bit_cnt = 4'h0;
			next_sda_oe  = 1'b0;
			next_wr_pend = 1'b0;
		end else if (stop) begin
			next_state   = DS_IDLE;
			next_sda_oe  = 1'b0;
			next_wr_pend = 1'b0;
			if (wr_pend && !wp) begin
				next_busy   = 1'b1;
				next_wtimer = SEEAE_WTIMER_W'(WRITE_CYCLES);
			end
		end else begin
			case (state)
				DS_RX: begin
					if (scl_rise) begin
						next_shreg   = {shreg[6:0], sda};
						next_bit_cnt = bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == SEEAE_BITS_BYTE) begin
						next_state  = DS_RX_ACK;
						next_sda_oe = 1'b1;
						case (kind)
							BK_CTRL: begin
								// Busy blocks every ack, which is what polling watches
								if (shreg[7:4] == SEEAE_DEV_CODE && shreg[3:1] == cs && !busy) begin
									next_rw = shreg[0];
								end else begin
									next_state  = DS_IDLE;
									next_sda_oe = 1'b0;
								end
							end
							BK_AHI: begin
								next_ptr[15:8] = shreg;
							end
							BK_ALO: begin
								next_ptr[7:0] = shreg;
								next_mask     = '0;
							end
							default: begin
								// Only the page offset counts; overflow rewrites the buffer
								buf_we                  = 1'b1;
								next_mask[ptr[6:0]]     = 1'b1;
								next_ptr[6:0]           = ptr[6:0] + 7'h01;
								next_wr_pend            = 1'b1;
							end
						endcase
					end
				end
				DS_RX_ACK: begin
					if (scl_fall) begin
						next_bit_cnt = 4'h0;
						if (kind == BK_CTRL && rw) begin
							next_state  = DS_TX;
							next_shreg  = mem[ptr];
							next_sda_oe = !mem[ptr][7];
						end else begin
							next_state  = DS_RX;
							next_sda_oe = 1'b0;
							next_kind   = (kind == BK_CTRL) ? BK_AHI : ((kind == BK_AHI) ? BK_ALO : BK_DATA);
						end
					end
				end
				DS_TX: begin
					if (scl_rise) begin
						next_bit_cnt = bit_cnt + 4'h1;
					end else if (scl_fall) begin
						if (bit_cnt == SEEAE_BITS_BYTE) begin
							// Full-width step wraps inside this device only
							next_state  = DS_TX_ACK;
							next_sda_oe = 1'b0;
							next_ptr    = ptr + 16'h0001;
						end else begin
							next_shreg  = {shreg[6:0], 1'b0};
							next_sda_oe = !shreg[6];
						end
					end
				end
				DS_TX_ACK: begin
					if (scl_rise) begin
						next_m_ack = !sda;
					end else if (scl_fall) begin
						next_bit_cnt = 4'h0;
						if (m_ack) begin
							next_state  = DS_TX;
							next_shreg  = mem[ptr];
							next_sda_oe = !mem[ptr][7];
						end else begin
							next_state  = DS_IDLE;
							next_sda_oe = 1'b0;
						end
					end
				end
				default: begin
					next_state  = DS_IDLE;
					next_sda_oe = 1'b0;
				end
			endcase
		end
	end
	// Control registers
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			state   <= DS_IDLE;
			kind    <= BK_CTRL;
			bit_cnt <= 4'h0;
			shreg   <= SEEAE_RST_BYTE;
			ptr     <= SEEAE_RST_PTR;
			rw      <= 1'b0;
			m_ack   <= 1'b0;
			sda_oe  <= 1'b0;
			wr_pend <= 1'b0;
			busy    <= 1'b0;
			wtimer  <= '0;
			mask    <= '0;
		end else if (CE_I) begin
			state   <= next_state;
			kind    <= next_kind;
			bit_cnt <= next_bit_cnt;
			shreg   <= next_shreg;
			ptr     <= next_ptr;
			rw      <= next_rw;
			m_ack   <= next_m_ack;
			sda_oe  <= next_sda_oe;
			wr_pend <= next_wr_pend;
			busy    <= next_busy;
			wtimer  <= next_wtimer;
			mask    <= next_mask;
		end
	end
	// Page buffer and array; a commit rewrites the whole page, unmasked bytes with old data
	always_ff @(posedge CORE_CLK_I) begin
		if (CE_I) begin
			if (buf_we) begin
				page_buf[ptr[6:0]] <= shreg;
			end
			if (commit) begin
				for (int i = 0; i < SEEAE_PAGE_BYTES; i++) begin
					mem[{ptr[15:7], 7'(i)}] <= mask[i] ? page_buf[i] : mem[{ptr[15:7], 7'(i)}];
				end
			end
		end
	end
	// Open-drain data: only ever pulls low
	assign LINK.dev_sda_o  = 1'b0;
	assign LINK.dev_sda_oe = sda_oe;
	assign BUSY_O          = busy;
endmodule : seeae_device

/* hw/seeae_host.sv */
// Two-wire bus master end: byte sequencer with command registers
`timescale 1ns/1ps
module seeae_host
	import seeae_pkg::*;
(
	// Clock, reset and enable
	input  logic       CORE_CLK_I,
	input  logic       RST_I,
	input  logic       CE_I,
	// Register port
	input  logic [1:0] ADDR_I,
	input  logic [7:0] WDATA_I,
	input  logic       WR_I,
	input  logic       RD_I,
	output logic [7:0] RDATA_O,
	// Two-wire link
	seeae_link_if.host LINK
);
	seeae_host_state_type state;
	seeae_host_state_type next_state;
	logic [7:0] qtimer;
	logic [1:0] phase;
	logic [3:0] bit_cnt;
	logic [4:0] cmd;
	logic [7:0] shreg;
	logic [7:0] rx_byte;
	logic       nacked;
	logic       scl;
	logic       sda_oe;
	logic       sda_s1;
	logic       sda_s2;
	logic [7:0] rdata;
	logic [7:0] next_qtimer;
	logic [1:0] next_phase;
	logic [3:0] next_bit_cnt;
	logic [4:0] next_cmd;
	logic [7:0] next_shreg;
	logic [7:0] next_rx_byte;
	logic       next_nacked;
	logic       next_scl;
	logic       next_sda_oe;
	logic [7:0] next_rdata;
	logic       idle;
	logic       tick;

	// Clock divider ticks four times per link clock period
	always_comb begin
		idle         = (state == HS_IDLE);
		tick         = !idle && (qtimer == 8'h00);
		next_state   = state;
		next_qtimer  = tick ? SEEAE_QTR_LOAD : qtimer - 8'h01;
		next_phase   = tick ? phase + 2'h1 : phase;
		next_bit_cnt = bit_cnt;
		next_cmd     = cmd;
		next_shreg   = shreg;
		next_rx_byte = rx_byte;
		next_nacked  = nacked;
		next_scl     = scl;
		next_sda_oe  = sda_oe;
		next_rdata   = SEEAE_RST_BYTE;

		// Reads answer one cycle later; writes while busy are ignored
		if (RD_I) begin
			case (ADDR_I)
				SEEAE_REG_DATA:   next_rdata = rx_byte;
				SEEAE_REG_STATUS: next_rdata = {6'h00, nacked, !idle};
				default:          next_rdata = SEEAE_RST_BYTE;
			endcase
		end
		if (idle) begin
			next_qtimer = SEEAE_QTR_LOAD;
			next_phase  = 2'h0;
			// Software builds the control byte, chip selects and page-safe bursts
			if (WR_I && ADDR_I == SEEAE_REG_DATA) begin
				next_shreg = WDATA_I;
			end
			if (WR_I && ADDR_I == SEEAE_REG_CMD) begin
				next_cmd     = WDATA_I[4:0];
				next_bit_cnt = 4'h0;
				if (WDATA_I[SEEAE_CMD_STOPONLY]) begin
					next_state = HS_STOP;
				end else if (WDATA_I[SEEAE_CMD_START]) begin
					next_state = HS_START;
				end else begin
					next_state = HS_BIT;
				end
			end
		end else if (tick) begin
			case (state)
				HS_START: begin
					case (phase)
						2'h0: begin
							next_scl    = 1'b0;
							next_sda_oe = 1'b0;
						end
						2'h1: next_scl = 1'b1;
						2'h2: next_sda_oe = 1'b1;
						default: begin
							next_scl   = 1'b0;
							next_state = HS_BIT;
						end
					endcase
				end
				HS_BIT: begin
					case (phase)
						2'h0: begin
							next_scl = 1'b0;
							if (bit_cnt != SEEAE_BITS_BYTE) begin
								next_sda_oe = !cmd[SEEAE_CMD_READ] && !shreg[7];
							end else begin
								next_sda_oe = cmd[SEEAE_CMD_READ] && !cmd[SEEAE_CMD_NACK];
							end
						end
						2'h1: next_scl = 1'b1;
						2'h2: begin
							if (bit_cnt != SEEAE_BITS_BYTE) begin
								next_shreg = {shreg[6:0], cmd[SEEAE_CMD_READ] && sda_s2};
							end else if (!cmd[SEEAE_CMD_READ]) begin
								next_nacked = sda_s2;
							end
						end
						default: begin
							next_scl     = 1'b0;
							next_bit_cnt = bit_cnt + 4'h1;
							if (bit_cnt == SEEAE_BITS_BYTE) begin
								next_rx_byte = shreg;
								next_state   = cmd[SEEAE_CMD_STOP] ? HS_STOP : HS_IDLE;
							end
						end
					endcase
				end
				HS_STOP: begin
					case (phase)
						2'h0: begin
							next_scl    = 1'b0;
							next_sda_oe = 1'b1;
						end
						2'h1: next_scl = 1'b1;
						2'h2: next_sda_oe = 1'b0;
						default: next_state = HS_IDLE;
					endcase
				end
				default: next_state = HS_IDLE;
			endcase
		end
	end

	// State registers; data line passes two flip-flops first
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			state   <= HS_IDLE;
			qtimer  <= SEEAE_QTR_LOAD;
			phase   <= 2'h0;
			bit_cnt <= 4'h0;
			cmd     <= 5'h00;
			shreg   <= SEEAE_RST_BYTE;
			rx_byte <= SEEAE_RST_BYTE;
			nacked  <= 1'b0;
			scl     <= 1'b1;
			sda_oe  <= 1'b0;
			sda_s1  <= 1'b1;
			sda_s2  <= 1'b1;
			rdata   <= SEEAE_RST_BYTE;
		end else if (CE_I) begin
			state   <= next_state;
			qtimer  <= next_qtimer;
			phase   <= next_phase;
			bit_cnt <= next_bit_cnt;
			cmd     <= next_cmd;
			shreg   <= next_shreg;
			rx_byte <= next_rx_byte;
			nacked  <= next_nacked;
			scl     <= next_scl;
			sda_oe  <= next_sda_oe;
			sda_s1  <= LINK.sda;
			sda_s2  <= sda_s1;
			rdata   <= next_rdata;
		end
	end

	assign LINK.scl         = scl;
	assign LINK.host_sda_o  = 1'b0;
	assign LINK.host_sda_oe = sda_oe;
	assign RDATA_O          = rdata;

endmodule : seeae_host

/* sim/seeae_link_sva.sv */
// Concurrent checks on the two-wire link and the device busy flag
`timescale 1ns/1ps
module seeae_link_sva #(
	parameter int unsigned WRITE_CYCLES = 1500
) (
	// Clock and reset
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	// Link lines
	input wire logic scl,
	input wire logic sda,
	input wire logic dev_sda_oe,
	// Device status and strap
	input wire logic BUSY_O,
	input wire logic WP_I
);
	logic        scl_q, sda_q, stop_ev;
	logic        next_scl_q, next_sda_q;
	logic [3:0]  since_stop, next_since_stop;
	logic [3:0]  since_fall, next_since_fall;
	logic [31:0] busy_cnt, next_busy_cnt;
	// The since counters saturate so that an old event never looks fresh; busy_cnt clears when not busy
	always_comb begin
		stop_ev = scl && scl_q && sda && !sda_q;
		next_scl_q = scl;
		next_sda_q = sda;
		next_since_stop = stop_ev ? 4'h0 : since_stop + 4'(since_stop != 4'hf);
		next_since_fall = (scl_q && !scl) ? 4'h0 : since_fall + 4'(since_fall != 4'hf);
		next_busy_cnt = BUSY_O ? busy_cnt + 32'h1 : 32'h0;
	end
	// Helper registers
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			since_stop <= 4'hf;
			since_fall <= 4'hf;
			busy_cnt <= 32'h0;
		end else begin
			scl_q <= next_scl_q;
			sda_q <= next_sda_q;
			since_stop <= next_since_stop;
			since_fall <= next_since_fall;
			busy_cnt <= next_busy_cnt;
		end
	end
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);
	property p_quiet_busy; BUSY_O |-> !dev_sda_oe; endproperty
	a_quiet_busy: assert property (p_quiet_busy) else $error("Device drove data while busy");
	property p_busy_after_stop; $rose(BUSY_O) |-> since_stop <= 4'h8; endproperty
	a_busy_after_stop: assert property (p_busy_after_stop) else $error("Busy rose without a Stop");
	property p_busy_len; $fell(BUSY_O) |-> busy_cnt == WRITE_CYCLES; endproperty
	a_busy_len: assert property (p_busy_len) else $error("Write cycle length wrong");
	property p_wp_block; (stop_ev && WP_I) |-> ##1 (!BUSY_O) [*8]; endproperty
	a_wp_block: assert property (p_wp_block) else $error("Protected write started a cycle");
	property p_drive_after_fall; $changed(dev_sda_oe) |-> since_fall inside {[4'h1:4'h5]}; endproperty
	a_drive_after_fall: assert property (p_drive_after_fall) else $error("Data changed late");
	property p_hold_high; (scl && $past(scl)) |-> $stable(dev_sda_oe); endproperty
	a_hold_high: assert property (p_hold_high) else $error("Data changed with clock high");
	property p_ack_in_low; $rose(dev_sda_oe) |-> (!scl) [*8]; endproperty
	a_ack_in_low: assert property (p_ack_in_low) else $error("Drive began near a clock rise");
	property p_idle_reset; $fell(RST_I) |-> scl && sda && !dev_sda_oe; endproperty
	a_idle_reset: assert property (p_idle_reset) else $error("Link not idle after reset");
	property p_release_stop; stop_ev |-> !dev_sda_oe; endproperty
	a_release_stop: assert property (p_release_stop) else $error("Device held data at Stop");
	c_write_cycle: cover property ($fell(BUSY_O));
	c_protect: cover property (stop_ev && WP_I);
	c_dev_drive: cover property ($rose(dev_sda_oe));
endmodule : seeae_link_sva

/* sim/testbench.sv */
// Bench joining host and device ends across the two-wire link
`timescale 1ns/1ps
module testbench;
	import seeae_pkg::*;
	// Write time longer than one polling byte, so polling is refused once
	localparam int unsigned WCYC = 1500;
	localparam logic [7:0]  K_S  = 8'h01 << SEEAE_CMD_START;
	localparam logic [7:0]  K_P  = 8'h01 << SEEAE_CMD_STOP;
	localparam logic [7:0]  K_R  = 8'h01 << SEEAE_CMD_READ;
	localparam logic [7:0]  K_N  = 8'h01 << SEEAE_CMD_NACK;
	localparam logic [7:0]  K_O  = 8'h01 << SEEAE_CMD_STOPONLY;
	// Stimulus, observation and bookkeeping
	logic        clk    = 1'b0;
	logic        rst    = 1'b1;
	logic        wp     = 1'b0;
	logic [2:0]  cs     = 3'h0;
	logic [1:0]  addr   = 2'h0;
	logic [7:0]  wdata  = 8'h00;
	logic        wr     = 1'b0;
	logic        rd     = 1'b0;
	logic        rd_chk = 1'b0;
	logic        chk_d  = 1'b0;
	logic        scl_d  = 1'b1;
	logic [8:0]  sh     = 9'h000;
	logic [7:0]  rdata, cw, cr;
	logic        busy;
	logic [15:0] note;
	logic [7:0]  d[7];
	logic [7:0]  bq[$];
	logic [15:0] notes[$];
	int          miscompares = 0;
	int          compares    = 0;
	int          seed        = 72;
	seeae_link_if link ();
	seeae_device #(.WRITE_CYCLES(WCYC)) i_seeae_device (.CORE_CLK_I(clk), .RST_I(rst), .CE_I(1'b1),
		.WP_I(wp), .CS_I(cs), .BUSY_O(busy), .LINK(link.dev));
	seeae_host i_seeae_host (.CORE_CLK_I(clk), .RST_I(rst), .CE_I(1'b1), .ADDR_I(addr), .WDATA_I(wdata),
		.WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .LINK(link.host));
	seeae_link_sva #(.WRITE_CYCLES(WCYC)) i_seeae_link_sva (.CORE_CLK_I(clk), .RST_I(rst), .scl(link.scl),
		.sda(link.sda), .dev_sda_oe(link.dev_sda_oe), .BUSY_O(busy), .WP_I(wp));
	// Clock of 100 ns
	always #50 clk = ~clk;
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : conclude
	// Each noted read is compared with what the host returns a cycle later
	always @(posedge clk) begin
		if (chk_d) begin
			note = notes.pop_front();
			check(rdata & note[15:8], note[7:0]);
		end
		chk_d <= rd_chk;
	end
	// Data is shifted in at each link clock rise, as a receiver sees it
	always @(posedge clk) begin
		scl_d <= link.scl;
		if (link.scl && !scl_d) sh <= {sh[7:0], link.sda};
	end
	task automatic reg_wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : reg_wr
	// A zero mask reads without noting an expectation
	task automatic reg_rd(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e, output logic [7:0] v);
		@(posedge clk);
		if (m != 8'h00) notes.push_back({m, e});
		addr <= a;
		rd <= 1'b1;
		rd_chk <= (m != 8'h00);
		@(posedge clk);
		rd <= 1'b0;
		rd_chk <= 1'b0;
		#1 v = rdata;
	endtask : reg_rd
	// One byte on the link, then the status or received byte is checked
	task automatic xfer(input logic [7:0] cmd, input logic [7:0] tx, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] v;
		int         n;
		reg_wr(SEEAE_REG_DATA, tx);
		reg_wr(SEEAE_REG_CMD, cmd);
		v = 8'h01;
		for (n = 0; n < 2000 && v[SEEAE_ST_BUSY] !== 1'b0; n++) reg_rd(SEEAE_REG_STATUS, 8'h00, 8'h00, v);
		if (v[SEEAE_ST_BUSY] !== 1'b0) begin
			miscompares++;
			$display("ERROR at %0t: host never went idle", $time);
			conclude();
		end
		if (cmd[SEEAE_CMD_READ]) reg_rd(SEEAE_REG_DATA, m, e, v);
		else if (m != 8'h00) reg_rd(SEEAE_REG_STATUS, m, e, v);
		if (!cmd[SEEAE_CMD_READ] && !cmd[SEEAE_CMD_STOP] && !cmd[SEEAE_CMD_STOPONLY]) check(sh[8:1], tx);
	endtask : xfer
	// Polling: refused while the write cycle runs, then accepted
	task automatic poll(input int nref);
		for (int k = 0; k <= nref; k++) xfer(K_S, cw, 8'h02, (k < nref) ? 8'h02 : 8'h00);
	endtask : poll
	// The queued bytes are written from one address, the last with Stop
	task automatic mem_wr(input logic [15:0] a);
		xfer(K_S, cw, 8'h02, 8'h00);
		xfer(8'h00, a[15:8], 8'h02, 8'h00);
		xfer(8'h00, a[7:0], 8'h02, 8'h00);
		foreach (bq[i]) xfer((i == bq.size() - 1) ? K_P : 8'h00, bq[i], 8'h02, 8'h00);
	endtask : mem_wr
	// The queued bytes are expected back; the last is refused and Stop follows
	task automatic mem_rd(input logic [15:0] a, input logic ra);
		if (ra) begin
			xfer(K_S, cw, 8'h02, 8'h00);
			xfer(8'h00, a[15:8], 8'h02, 8'h00);
			xfer(8'h00, a[7:0], 8'h02, 8'h00);
		end
		xfer(K_S, cr, 8'h02, 8'h00);
		foreach (bq[i]) xfer(K_R | ((i == bq.size() - 1) ? (K_N | K_P) : 8'h00), 8'h00, 8'hff, bq[i]);
		check({6'h00, link.scl, link.sda}, 8'h03);
	endtask : mem_rd
	// Main sequence
	initial begin
		cw = {SEEAE_DEV_CODE, 3'($random(seed)), 1'b0};
		cr = cw | 8'h01;
		foreach (d[i]) d[i] = 8'($random(seed));
		cs <= cw[3:1];
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		xfer(K_S, cw ^ 8'h02, 8'h02, 8'h02);
		xfer(K_S, cw ^ 8'h80, 8'h02, 8'h02);
		xfer(K_O, 8'h00, 8'h00, 8'h00);
		$display("Test 1 done: selection");
		bq = {d[0], d[1], d[2]};
		mem_wr(16'h1234);
		poll(1);
		bq = {d[3]};
		mem_wr(16'h1233);
		poll(1);
		bq = {d[0]};
		mem_rd(16'h0000, 1'b0);
		bq = {d[1]};
		mem_rd(16'h1235, 1'b1);
		bq = {d[2]};
		mem_rd(16'h0000, 1'b0);
		bq = {d[3], d[0], d[1], d[2]};
		mem_rd(16'h1233, 1'b1);
		$display("Test 2 done: writes and reads");
		@(posedge clk) wp <= 1'b1;
		bq = {~d[0]};
		mem_wr(16'h1234);
		poll(0);
		@(posedge clk) wp <= 1'b0;
		bq = {d[0]};
		mem_rd(16'h1234, 1'b1);
		$display("Test 3 done: protection");
		bq = {d[4], d[5]};
		mem_wr(16'h007f);
		@(posedge clk) wp <= 1'b1;
		poll(1);
		@(posedge clk) wp <= 1'b0;
		bq = {d[6]};
		mem_wr(16'hffff);
		poll(1);
		bq = {d[6], d[5]};
		mem_rd(16'hffff, 1'b1);
		$display("Test 4 done: wrapping");
		conclude();
	end
endmodule : testbench
